// ---- design/byte_fifo.v ----
// Byte FIFO between the array fetch and the serial shifter.
`timescale 1ns/1ps
module byte_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
)
(
	input  wire             clk,
	input  wire             rst,
	input  wire             flush,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;

	assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	always @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end

endmodule // byte_fifo

// ---- design/flash_read_defs.vh ----
// Constants shared by the serial flash read front end.
`ifndef FLASH_READ_DEFS_VH
`define FLASH_READ_DEFS_VH

`define OP_ENTER_WIDE   8'hB7
`define OP_EXIT_WIDE    8'hE9
`define OP_READ         8'h03
`define OP_READ_WIDE    8'h13
`define OP_FAST         8'h0B
`define OP_FAST_WIDE    8'h0C
`define OP_DUAL         8'h3B
`define OP_DUAL_WIDE    8'h3C
`define OP_QUAD         8'h6B
`define OP_QUAD_WIDE    8'h6C
`define OP_SET_PARAMS   8'hC0

`define OPCODE_BITS     6'h08
`define ADDR_BITS_NARROW 6'h18
`define ADDR_BITS_WIDE  6'h20
`define DUMMY_SINGLE    4'h8
`define PARAM_DC_LSB    4
`define PARAM_RESET     8'h00
`define EXT_ADDR_RESET  8'h00
`define FIFO_WIDTH      8
`define FIFO_DEPTH      32
`define FIFO_AW         5

`define LANES_ONE       2'h0
`define LANES_TWO       2'h1
`define LANES_FOUR      2'h2

`endif

// ---- design/flash_read_front.v ----
// Serial flash read front end: address mode, read opcodes, lane output.
`timescale 1ns/1ps
`include "flash_read_defs.vh"
module flash_read_front
(
	input  wire        CLK,
	input  wire        RST,
	input  wire        CS_N_PIN,
	input  wire        SCLK_PIN,
	input  wire [3:0]  LANE_IN,
	output reg  [3:0]  LANE_OUT,
	output reg  [3:0]  LANE_OE,
	input  wire        BUSY,
	input  wire        QUAD_ENABLE_BIT,
	input  wire        FOUR_LANE_COMMAND_MODE,
	input  wire [7:0]  EXT_ADDR_IN,
	input  wire        EXT_ADDR_WE,
	output reg  [7:0]  EXT_ADDR,
	output reg         ADDRESS_SIZE_FLAG,
	output reg  [7:0]  READ_PARAMS,
	output reg  [31:0] MEM_ADDR,
	output reg         MEM_REQ,
	input  wire [7:0]  MEM_DATA,
	input  wire        MEM_VALID,
	output reg         MEM_READY
);

	// ==========================================================
	// Local states and helpers

	localparam ST_IDLE  = 3'h0;
	localparam ST_OP    = 3'h1;
	localparam ST_ADDR  = 3'h2;
	localparam ST_DUMMY = 3'h3;
	localparam ST_DATA  = 3'h4;
	localparam ST_PARAM = 3'h5;
	localparam ST_SKIP  = 3'h6;
	function is_read;
		input [7:0] op;
		input       four;
		input       qe;
		begin
			case (op)
				`OP_FAST:      is_read = 1'b1;
				`OP_READ,
				`OP_READ_WIDE,
				`OP_FAST_WIDE,
				`OP_DUAL,
				`OP_DUAL_WIDE,
				`OP_QUAD_WIDE: is_read = ~four;
				`OP_QUAD:      is_read = ~four & qe;
				default:       is_read = 1'b0;
			endcase
		end
	endfunction
	function is_wide;
		input [7:0] op;
		begin
			is_wide = (op == `OP_READ_WIDE) || (op == `OP_FAST_WIDE) ||
			          (op == `OP_DUAL_WIDE) || (op == `OP_QUAD_WIDE);
		end
	endfunction

	// ==========================================================
	// Pin synchronisers and serial clock edges

	reg  [1:0] cs_sync_q;
	reg  [1:0] sck_sync_q;
	reg  [3:0] lane_s1_q;
	reg  [3:0] lane_s2_q;
	reg        sck_prev_q;
	wire       cs_low;
	wire       rise;
	wire       fall;

	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			cs_sync_q  <= 2'h3;
			sck_sync_q <= 2'h0;
			lane_s1_q  <= 4'h0;
			lane_s2_q  <= 4'h0;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			cs_sync_q  <= {cs_sync_q[0], CS_N_PIN};
			sck_sync_q <= {sck_sync_q[0], SCLK_PIN};
			lane_s1_q  <= LANE_IN;
			lane_s2_q  <= lane_s1_q;
			sck_prev_q <= sck_sync_q[1];
		end
	end

	assign cs_low = ~cs_sync_q[1];
	assign rise   = cs_low & sck_sync_q[1] & ~sck_prev_q;
	assign fall   = cs_low & ~sck_sync_q[1] & sck_prev_q;

	// ==========================================================
	// Data FIFO between array and shifter

	wire [7:0] fifo_data;
	wire       fifo_valid;
	wire       fifo_in_ready;
	reg        fifo_pop;
	reg        flush_q;
	byte_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.flush     (flush_q),
		.in_data   (MEM_DATA),
		.in_valid  (MEM_VALID & MEM_REQ),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// ==========================================================
	// Command sequencer

	reg [2:0]  state_q;
	reg [7:0]  op_q;
	reg [5:0]  cnt_q;
	reg [31:0] addr_q;
	reg [5:0]  addr_len_q;
	reg [3:0]  dummy_q;
	reg [1:0]  lanes_q;
	reg [7:0]  shift_q;
	reg [3:0]  bits_q;
	reg        prim_q;
	reg        busy_op_q;
	wire [7:0] op_next;
	wire [1:0] step;
	wire [3:0] four_dummy;
	assign op_next    = FOUR_LANE_COMMAND_MODE ? {op_q[3:0], lane_s2_q} : {op_q[6:0], lane_s2_q[0]};
	assign step       = (lanes_q == `LANES_FOUR) ? 2'h3 : ((lanes_q == `LANES_TWO) ? 2'h2 : 2'h1);
	assign four_dummy = {2'h0, READ_PARAMS[`PARAM_DC_LSB+1:`PARAM_DC_LSB]} * 4'h2 + 4'h2;
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_q           <= ST_IDLE;
			op_q              <= 8'h00;
			cnt_q             <= 6'h00;
			addr_q            <= 32'h00000000;
			addr_len_q        <= `ADDR_BITS_NARROW;
			dummy_q           <= 4'h0;
			lanes_q           <= `LANES_ONE;
			shift_q           <= 8'h00;
			bits_q            <= 4'h0;
			prim_q            <= 1'b0;
			busy_op_q         <= 1'b0;
			flush_q           <= 1'b0;
			fifo_pop          <= 1'b0;
			LANE_OUT          <= 4'h0;
			LANE_OE           <= 4'h0;
			EXT_ADDR          <= `EXT_ADDR_RESET;
			ADDRESS_SIZE_FLAG <= 1'b0;
			READ_PARAMS       <= `PARAM_RESET;
			MEM_ADDR          <= 32'h00000000;
			MEM_REQ           <= 1'b0;
			MEM_READY         <= 1'b0;
		end
		else
		begin
			flush_q   <= 1'b0;
			fifo_pop  <= 1'b0;
			MEM_READY <= fifo_in_ready;
			if (EXT_ADDR_WE)
				EXT_ADDR <= EXT_ADDR_IN;
			if (MEM_REQ && MEM_VALID && fifo_in_ready)
				MEM_ADDR <= MEM_ADDR + 32'h00000001;
			if (!cs_low)
			begin
				if (state_q == ST_SKIP && cnt_q == 6'h00 && !busy_op_q &&
				    (op_q == `OP_ENTER_WIDE || op_q == `OP_EXIT_WIDE))
					ADDRESS_SIZE_FLAG <= (op_q == `OP_ENTER_WIDE);
				state_q  <= ST_IDLE;
				LANE_OE  <= 4'h0;
				MEM_REQ  <= 1'b0;
				flush_q  <= (state_q != ST_IDLE);
				cnt_q    <= 6'h00;
			end
			else
			begin
				case (state_q)
					ST_IDLE:
					begin
						state_q   <= ST_OP;
						busy_op_q <= BUSY;
					end
					ST_OP:
					begin
						if (rise && cnt_q < `OPCODE_BITS)
						begin
							op_q  <= op_next;
							cnt_q <= cnt_q + (FOUR_LANE_COMMAND_MODE ? 6'h04 : 6'h01);
						end
						else if (cnt_q == `OPCODE_BITS)
						begin
							cnt_q <= 6'h00;
							if (busy_op_q)
								state_q <= ST_SKIP;
							else if (is_read(op_q, FOUR_LANE_COMMAND_MODE, QUAD_ENABLE_BIT))
							begin
								state_q <= ST_ADDR;
								addr_len_q <= (is_wide(op_q) || ADDRESS_SIZE_FLAG) ?
								              `ADDR_BITS_WIDE : `ADDR_BITS_NARROW;
								if (op_q == `OP_READ || op_q == `OP_READ_WIDE)
									dummy_q <= 4'h0;
								else if (FOUR_LANE_COMMAND_MODE)
									dummy_q <= four_dummy;
								else
									dummy_q <= `DUMMY_SINGLE;
								if (op_q == `OP_DUAL || op_q == `OP_DUAL_WIDE)
									lanes_q <= `LANES_TWO;
								else if (op_q == `OP_QUAD || op_q == `OP_QUAD_WIDE ||
								         FOUR_LANE_COMMAND_MODE)
									lanes_q <= `LANES_FOUR;
								else
									lanes_q <= `LANES_ONE;
							end
							else if (op_q == `OP_SET_PARAMS && FOUR_LANE_COMMAND_MODE)
								state_q <= ST_PARAM;
							else
								state_q <= ST_SKIP;
						end
					end
					ST_ADDR:
					begin
						if (rise)
						begin
							addr_q <= FOUR_LANE_COMMAND_MODE ? {addr_q[27:0], lane_s2_q} :
							          {addr_q[30:0], lane_s2_q[0]};
							cnt_q  <= cnt_q + (FOUR_LANE_COMMAND_MODE ? 6'h04 : 6'h01);
						end
						else if (cnt_q == addr_len_q)
						begin
							MEM_ADDR <= (addr_len_q == `ADDR_BITS_WIDE) ? addr_q :
							            {EXT_ADDR, addr_q[23:0]};
							MEM_REQ  <= 1'b1;
							cnt_q    <= 6'h00;
							state_q  <= (dummy_q == 4'h0) ? ST_DATA : ST_DUMMY;
							prim_q   <= 1'b1;
						end
					end
					ST_DUMMY:
					begin
						if (rise)
						begin
							dummy_q <= dummy_q - 4'h1;
							if (dummy_q == 4'h1)
								state_q <= ST_DATA;
						end
					end
					ST_DATA:
					begin
						if (prim_q && fifo_valid)
						begin
							shift_q  <= fifo_data;
							bits_q   <= 4'h8;
							fifo_pop <= 1'b1;
							prim_q   <= 1'b0;
						end
						else if (fall && !prim_q)
						begin
							if (lanes_q == `LANES_ONE)
							begin
								LANE_OUT <= {2'h0, shift_q[7], 1'b0};
								LANE_OE  <= 4'h2;
							end
							else if (lanes_q == `LANES_TWO)
							begin
								LANE_OUT <= {2'h0, shift_q[7:6]};
								LANE_OE  <= 4'h3;
							end
							else
							begin
								LANE_OUT <= shift_q[7:4];
								LANE_OE  <= 4'hF;
							end
							if (bits_q == {2'h0, step} + ((lanes_q == `LANES_FOUR) ? 4'h1 : 4'h0))
								prim_q <= 1'b1;
							shift_q <= (lanes_q == `LANES_FOUR) ? {shift_q[3:0], 4'h0} :
							           ((lanes_q == `LANES_TWO) ? {shift_q[5:0], 2'h0} :
							           {shift_q[6:0], 1'b0});
							bits_q  <= bits_q - ((lanes_q == `LANES_FOUR) ? 4'h4 :
							           {2'h0, step});
						end
					end
					ST_PARAM:
					begin
						if (rise && cnt_q < `OPCODE_BITS)
						begin
							shift_q <= {shift_q[3:0], lane_s2_q};
							cnt_q   <= cnt_q + 6'h04;
						end
						else if (cnt_q == `OPCODE_BITS)
						begin
							READ_PARAMS <= shift_q;
							state_q     <= ST_SKIP;
						end
					end
					ST_SKIP:
						cnt_q <= rise ? `OPCODE_BITS : cnt_q;
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

endmodule // flash_read_front

// ---- sim/flash_host_model.sv ----
// Host controller model driving select, serial clock and lanes.
`timescale 1ns/1ps
module flash_host_model
(
	input  wire       clk,
	output reg        cs_n,
	output reg        sclk,
	output wire [3:0] lane_wire,
	input  wire [3:0] lane_out,
	input  wire [3:0] lane_oe
);
	reg [3:0] drv;
	reg [3:0] hoe;
	reg [3:0] smp;
	reg       tgl;
	// Undriven lanes toggle so a stale level never passes for data.
	assign lane_wire = (lane_oe & lane_out) | (~lane_oe & hoe & drv) | (~lane_oe & ~hoe & {4{tgl}});
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
		hoe = 4'h1;
		tgl = 1'b0;
	end
	always @(posedge clk)
		tgl <= ~tgl;
	// ==========
	// Serial clock cycles
	// data set on falling edge.
	task tick(input [3:0] d);
	begin
		@(posedge clk);
		#1;
		smp = lane_wire;
		sclk = 1'b0;
		drv = d;
		repeat (4) @(posedge clk);
		#1;
		sclk = 1'b1;
		repeat (3) @(posedge clk);
	end
	endtask
	task open(input [3:0] lanes);
	begin
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		hoe = lanes;
	end
	endtask
	task send(input [31:0] v, input integer n, input integer w);
		integer i;
	begin
		for (i = n - w; i >= 0; i = i - w)
			tick((w == 4) ? v[i +: 4] : {3'b000, v[i]});
	end
	endtask
	// release lanes, hold clock high for the fetch.
	task rd_start;
	begin
		@(posedge clk);
		#1;
		hoe = 4'h0;
		repeat (16) @(posedge clk);
		tick(4'h0);
	end
	endtask
	task rd_byte(input integer w, output [7:0] b);
		integer k;
	begin
		for (k = 0; k < 8; k = k + w)
		begin
			tick(4'h0);
			b = (w == 4) ? {b[3:0], smp} : (w == 2) ? {b[5:0], smp[1:0]} : {b[6:0], smp[1]};
		end
	end
	endtask
	task close;
	begin
		@(posedge clk);
		#1;
		sclk = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		cs_n = 1'b1;
		hoe = 4'h1;
		repeat (8) @(posedge clk);
		#1;
	end
	endtask
endmodule // flash_host_model

// ---- sim/flash_read_front_checker.sv ----
// Port checks for the flash read front end.
`timescale 1ns/1ps
module flash_read_front_checker
(
	input wire        CLK,
	input wire        RST,
	input wire        CS_N_PIN,
	input wire        BUSY,
	input wire        FOUR_LANE_COMMAND_MODE,
	input wire [7:0]  EXT_ADDR_IN,
	input wire        EXT_ADDR_WE,
	input wire [7:0]  EXT_ADDR,
	input wire        ADDRESS_SIZE_FLAG,
	input wire [7:0]  READ_PARAMS,
	input wire [3:0]  LANE_OE,
	input wire [31:0] MEM_ADDR,
	input wire        MEM_REQ,
	input wire        MEM_READY
);
	reg busy_q;
	reg cs_q;
	// ==========
	// Busy frame tracking
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			busy_q <= 1'b0;
			cs_q   <= 1'b1;
		end
		else
		begin
			cs_q <= CS_N_PIN;
			if (CS_N_PIN)
				busy_q <= 1'b0;
			else if (cs_q)
				busy_q <= BUSY;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_busy_ignored: assert property (busy_q |-> !MEM_REQ && LANE_OE == 4'h0)
		else $error("busy frame acted");
	a_cs_ends_read: assert property (CS_N_PIN [*6] |-> !MEM_REQ)
		else $error("request outlived select");
	a_oe_release: assert property ($rose(CS_N_PIN) |-> ##[1:6] LANE_OE == 4'h0)
		else $error("lanes driven after select");
	a_lane_sets: assert property (LANE_OE inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("bad lane set");
	a_four_lane_out: assert property (FOUR_LANE_COMMAND_MODE |-> LANE_OE inside {4'h0, 4'hF})
		else $error("narrow output in four-lane mode");
	a_flag_at_edge: assert property ($changed(ADDRESS_SIZE_FLAG) |-> CS_N_PIN)
		else $error("flag changed in frame");
	a_ext_load: assert property (EXT_ADDR_WE |=> EXT_ADDR == $past(EXT_ADDR_IN))
		else $error("extended address not loaded");
	a_params_mode: assert property ($changed(READ_PARAMS) |-> FOUR_LANE_COMMAND_MODE)
		else $error("params changed outside four-lane mode");
	a_addr_step: assert property (MEM_REQ && $past(MEM_REQ, 2) && $changed(MEM_ADDR)
		|-> MEM_ADDR == $past(MEM_ADDR) + 32'h1)
		else $error("address did not step by one");
	c_quad: cover property (LANE_OE == 4'hF);
	c_dual: cover property (LANE_OE == 4'h3);
	c_full: cover property (MEM_REQ && !MEM_READY);
endmodule // flash_read_front_checker

// ---- sim/tb_top.sv ----
// Self-checking bench for the flash read front end.
`timescale 1ns/1ps
module tb_top;
	reg         clk;
	reg         rst;
	reg         busy;
	reg         qe;
	reg         four;
	reg  [7:0]  ext_in;
	reg         ext_we;
	reg  [7:0]  mem_data;
	reg         mem_valid;
	reg         mem_on;
	reg         seen;
	reg  [31:0] start;
	reg  [7:0]  b;
	wire        cs_n;
	wire        sclk;
	wire [3:0]  lanes;
	wire [3:0]  lo;
	wire [3:0]  oe;
	wire [7:0]  ext;
	wire        address_size_flag;
	wire [7:0]  prm;
	wire [31:0] ma;
	wire        req;
	wire        rdy;
	integer     err_count;
	integer     check_count;
	integer     cycles;
	integer     k;
	always #20 clk = ~clk;
	flash_read_front DUT
	(
		.CLK(clk), .RST(rst), .CS_N_PIN(cs_n), .SCLK_PIN(sclk), .LANE_IN(lanes),
		.LANE_OUT(lo), .LANE_OE(oe), .BUSY(busy), .QUAD_ENABLE_BIT(qe),
		.FOUR_LANE_COMMAND_MODE(four), .EXT_ADDR_IN(ext_in), .EXT_ADDR_WE(ext_we),
		.EXT_ADDR(ext), .ADDRESS_SIZE_FLAG(address_size_flag), .READ_PARAMS(prm), .MEM_ADDR(ma),
		.MEM_REQ(req), .MEM_DATA(mem_data), .MEM_VALID(mem_valid), .MEM_READY(rdy)
	);
	flash_host_model host
	(
		.clk(clk), .cs_n(cs_n), .sclk(sclk), .lane_wire(lanes), .lane_out(lo), .lane_oe(oe)
	);
	// ==========
	// Array model: byte value is the low address byte scrambled.
	always @(posedge clk)
	begin
		#1;
		mem_valid <= req & mem_on;
		mem_data <= ma[7:0] ^ 8'h5A;
		if (req && !seen)
			start = ma;
		seen = req;
		cycles = cycles + 1;
		if (cycles == 30000)
		begin
			err_count = err_count + 1;
			end_sim;
		end
	end
	task chk(input [8*6-1:0] nm, input [31:0] exp, input [31:0] got);
	begin
		check_count = check_count + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("mismatch %0s expected %h seen %h", nm, exp, got);
		end
	end
	endtask
	task setext(input [7:0] v);
	begin
		ext_in = v;
		ext_we = 1'b1;
		@(posedge clk);
		#1;
		ext_we = 1'b0;
	end
	endtask
	task cmd(input [7:0] op);
	begin
		host.open(4'h1);
		host.send({24'h0, op}, 8, 1);
		host.close;
	end
	endtask
	task refuse(input [7:0] op, input integer w);
	begin
		host.open((w == 4) ? 4'hF : 4'h1);
		host.send({24'h0, op}, 8, w);
		host.send(32'h0, 32, w);
		repeat (16) @(posedge clk);
		chk("req", 32'h0, {31'h0, req});
		chk("oe", 32'h0, {28'h0, oe});
		host.close;
	end
	endtask
	task rd(input [7:0] op, input [31:0] a, input integer ab, input integer dm,
		input integer cw, input integer w, input integer n, input [31:0] ex);
	begin
		start = 32'bx;
		host.open((cw == 4) ? 4'hF : 4'h1);
		host.send({24'h0, op}, 8, cw);
		host.send(a, ab, cw);
		if (dm > 0)
		begin
			host.send(32'h0, (dm - 1) * cw, cw);
			chk("early", 32'h0, {28'h0, oe});
			host.send(32'h0, cw, cw);
		end
		host.rd_start;
		chk("start", ex, start);
		for (k = 0; k < n; k = k + 1)
		begin
			host.rd_byte(w, b);
			chk("data", {24'h0, ex[7:0] + k[7:0]} ^ 32'h5A, {24'h0, b});
		end
		host.close;
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		busy = 1'b0;
		qe = 1'b0;
		four = 1'b0;
		ext_in = 8'h00;
		ext_we = 1'b0;
		mem_data = 8'h00;
		mem_valid = 1'b0;
		mem_on = 1'b1;
		seen = 1'b0;
		err_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("ext", 32'h0, {24'h0, ext});
		chk("ads", 32'h0, {31'h0, address_size_flag});
		chk("param", 32'h0, {24'h0, prm});
		repeat (4) @(posedge clk);
		#1;
		setext(8'h3C);
		rd(8'h03, 32'h1234FF, 24, 0, 1, 1, 2, 32'h3C1234FF);
		cmd(8'hB7);
		chk("ads", 32'h1, {31'h0, address_size_flag});
		rd(8'h0B, 32'hA0000010, 32, 8, 1, 1, 2, 32'hA0000010);
		rd(8'h3B, 32'h000001FE, 32, 8, 1, 2, 3, 32'h000001FE);
		cmd(8'hE9);
		chk("ads", 32'h0, {31'h0, address_size_flag});
		rd(8'h13, 32'h07000001, 32, 0, 1, 1, 1, 32'h07000001);
		rd(8'h0C, 32'h05000002, 32, 8, 1, 1, 1, 32'h05000002);
		rd(8'h3C, 32'h06000003, 32, 8, 1, 2, 1, 32'h06000003);
		qe = 1'b1;
		rd(8'h6C, 32'h09000004, 32, 8, 1, 4, 2, 32'h09000004);
		qe = 1'b0;
		refuse(8'h6B, 1);
		qe = 1'b1;
		setext(8'h21);
		host.open(4'h1);
		host.send(32'h6B, 8, 1);
		host.send(32'h000100, 24, 1);
		host.send(32'h0, 8, 1);
		host.rd_start;
		repeat (60) @(posedge clk);
		chk("start", 32'h21000100, start);
		chk("ready", 32'h0, {31'h0, rdy});
		mem_on = 1'b0;
		for (k = 0; k < 32; k = k + 1)
		begin
			host.rd_byte(4, b);
			chk("data", {24'h0, k[7:0] ^ 8'h5A}, {24'h0, b});
		end
		chk("ready", 32'h1, {31'h0, rdy});
		mem_on = 1'b1;
		host.close;
		busy = 1'b1;
		cmd(8'hB7);
		chk("ads", 32'h0, {31'h0, address_size_flag});
		refuse(8'h03, 1);
		busy = 1'b0;
		four = 1'b1;
		refuse(8'h03, 4);
		refuse(8'h0C, 4);
		rd(8'h0B, 32'h00ABCD, 24, 2, 4, 4, 0, 32'h2100ABCD);
		host.open(4'hF);
		host.send(32'hC0, 8, 4);
		host.send(32'h20, 8, 4);
		host.close;
		chk("param", 32'h2, {30'h0, prm[5:4]});
		rd(8'h0B, 32'h00ABCE, 24, 6, 4, 4, 0, 32'h2100ABCE);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("param", 32'h0, {24'h0, prm});
		chk("ext", 32'h0, {24'h0, ext});
		four = 1'b0;
		end_sim;
	end
endmodule // tb_top

bind flash_read_front flash_read_front_checker chk_i
(
	.CLK(CLK), .RST(RST), .CS_N_PIN(CS_N_PIN), .BUSY(BUSY),
	.FOUR_LANE_COMMAND_MODE(FOUR_LANE_COMMAND_MODE), .EXT_ADDR_IN(EXT_ADDR_IN),
	.EXT_ADDR_WE(EXT_ADDR_WE), .EXT_ADDR(EXT_ADDR), .ADDRESS_SIZE_FLAG(ADDRESS_SIZE_FLAG),
	.READ_PARAMS(READ_PARAMS), .LANE_OE(LANE_OE), .MEM_ADDR(MEM_ADDR), .MEM_REQ(MEM_REQ),
	.MEM_READY(MEM_READY)
);
